//--- logic/rtcia_pkg.sv
// Constants and carrier types of the clock indirect access and alarm block.
// Assumes one system clock; the slow clock is a divided enable tick.
package rtcia_pkg;
    // Register port addresses
    localparam logic [7:0] RTCIA_ADDR_SFR   = 8'hac;
    localparam logic [7:0] RTCIA_DATA_SFR   = 8'had;
    localparam logic [7:0] RTCIA_LOCK_SFR   = 8'hae;
    localparam logic [7:0] RTCIA_UNLOCKED   = 8'h02;
    localparam logic [7:0] RTCIA_ZERO8      = 8'h00;
    localparam int         RTCIA_AUTO_READ_ENABLE_BIT = 6;
    // Indirect register indexes
    localparam logic [4:0] RTCIA_IDX_CAP0   = 5'h00;
    localparam logic [4:0] RTCIA_IDX_CTRL   = 5'h04;
    localparam logic [4:0] RTCIA_IDX_ROUTE  = 5'h05;
    localparam logic [4:0] RTCIA_IDX_FLAGS  = 5'h06;
    localparam logic [4:0] RTCIA_IDX_ALM0   = 5'h08;
    localparam logic [4:0] RTCIA_IDX_ALMEND = 5'h13;
    // Control bits
    localparam int RTCIA_CTL_RUN  = 0;
    localparam int RTCIA_CTL_AEN  = 1;
    localparam int RTCIA_CTL_AUTO = 2;
    localparam int RTCIA_CTL_CAP  = 3;
    localparam int RTCIA_CTL_SET  = 4;
    // Route bits
    localparam int RTCIA_RT_RESET = 0;
    localparam int RTCIA_RT_WAKE  = 1;
    localparam int RTCIA_RT_IRQ   = 2;
    localparam int RTCIA_NUM_ALM  = 3;
    // Timing
    localparam int RTCIA_CLK_HZ       = 125_000_000;
    localparam int RTCIA_SLOW_HZ      = 32_768;
    localparam int RTCIA_SLOW_DIV     = RTCIA_CLK_HZ / RTCIA_SLOW_HZ;
    localparam int RTCIA_XFER_MAX_SLW = 2;
    localparam int RTCIA_XFER_MAX_CYC = RTCIA_XFER_MAX_SLW * RTCIA_SLOW_DIV;

    typedef struct packed {
        logic [7:0] addr;
        logic       wr;
        logic       rd;
        logic [7:0] wdata;
    } rtcia_sfr_req_t;

    typedef struct packed {
        logic reset_req;
        logic wake_req;
        logic irq_req;
    } rtcia_alarm_req_t;
endpackage

//--- logic/rtcia_top.sv
// Indirect access port and alarm comparator of the low power clock.
// Assumes a register port on clk; slow clock derived here as a tick.
//
// Summary of operation
// - Lock status register reads 0x02, meaning the interface is unlocked.
// - Writes to the lock status register change nothing.
// - Address register bit 6 turns automatic read on or off.
// - Address register bits 7 and 5 read zero; writes there ignored.
// - Address bits 4:0 select the internal register for indirect access.
// - Select field increments after each capture or alarm byte access.
// - Timer set or capture needs run on; completes within 2 slow cycles.
// - Full 32-bit timer equal to match value raises an alarm event.
// - With auto reset, timer clears on the same slow tick as the alarm 0 event.
// - Alarm events route to reset, wake-up or interrupt request.
// - Writing alarm event enable to zero clears the alarm flags.
// - Without auto reset, re-enabled same match recurs 2^32 slow cycles on.
// - Only alarm 0 triggers auto reset; alarms 1 and 2 do not.
// - Timer wraps from maximum to zero and keeps counting.
`timescale 1ns/100ps
module rtcia_top
    import rtcia_pkg::*;
(
    input  wire logic             clk,
    input  wire logic             resetn,
    input  wire rtcia_sfr_req_t   sfr_req,
    output logic [7:0]            sfr_rdata,
    output rtcia_alarm_req_t      alarm_req
);

    ////////////////////////////////////////////////////////////////////////////
    // Slow clock tick
    logic [11:0] div_r;
    logic        tick;

    assign tick = (div_r == 12'(RTCIA_SLOW_DIV - 1));

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            div_r <= 12'h000;
        end else if (tick) begin
            div_r <= 12'h000;
        end else begin
            div_r <= div_r + 12'h001;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Register port decode
    logic       addr_wr, lock_wr, ind_wr, ind_rd, byte_sel, ind_step;
    logic       auto_read_enable_r, fetch_r;
    logic [4:0] sel_r;
    logic [7:0] addr_val, ind_val, rd_buf_r;

    assign addr_wr  = sfr_req.wr && (sfr_req.addr == RTCIA_ADDR_SFR);
    assign lock_wr  = sfr_req.wr && (sfr_req.addr == RTCIA_LOCK_SFR);
    assign ind_wr   = sfr_req.wr && (sfr_req.addr == RTCIA_DATA_SFR);
    assign ind_rd   = sfr_req.rd && (sfr_req.addr == RTCIA_DATA_SFR);
    assign byte_sel = (sel_r < RTCIA_IDX_CTRL) ||
                      (sel_r >= RTCIA_IDX_ALM0 && sel_r <= RTCIA_IDX_ALMEND);
    assign ind_step = (ind_wr || ind_rd) && byte_sel;
    assign addr_val = {1'b0, auto_read_enable_r, 1'b0, sel_r};

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            auto_read_enable_r <= 1'b0;
            sel_r    <= 5'h00;
        end else if (addr_wr) begin
            auto_read_enable_r <= sfr_req.wdata[RTCIA_AUTO_READ_ENABLE_BIT];
            sel_r    <= sfr_req.wdata[4:0];
        end else if (ind_step) begin
            sel_r    <= sel_r + 5'h01;
        end
    end

    // Auto read refreshes the buffer one cycle after the select moves
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            fetch_r  <= 1'b0;
            rd_buf_r <= RTCIA_ZERO8;
        end else begin
            fetch_r <= (addr_wr && sfr_req.wdata[RTCIA_AUTO_READ_ENABLE_BIT]) ||
                       (ind_rd && auto_read_enable_r);
            if (fetch_r) begin
                rd_buf_r <= ind_val;
            end
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            sfr_rdata <= RTCIA_ZERO8;
        end else if (sfr_req.rd) begin
            case (sfr_req.addr)
                RTCIA_ADDR_SFR: sfr_rdata <= addr_val;
                RTCIA_LOCK_SFR: sfr_rdata <= RTCIA_UNLOCKED;
                RTCIA_DATA_SFR: sfr_rdata <= auto_read_enable_r ? rd_buf_r : ind_val;
                default:        sfr_rdata <= RTCIA_ZERO8;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Indirect registers
    logic [7:0]  cap_r [4];
    logic [7:0]  alm_r [RTCIA_NUM_ALM*4];
    logic [31:0] alm_val [RTCIA_NUM_ALM];
    logic [31:0] timer_r, cap_val;
    logic        run_r, aen_r, auto_r, cap_pend_r, set_pend_r;
    logic [2:0]  route_r, flags_r, ev;
    logic [4:0]  alm_off;

    assign alm_off = sel_r - RTCIA_IDX_ALM0;
    assign cap_val = {cap_r[3], cap_r[2], cap_r[1], cap_r[0]};

    always_comb begin
        ind_val = RTCIA_ZERO8;
        if (sel_r < RTCIA_IDX_CTRL) begin
            ind_val = cap_r[sel_r[1:0]];
        end else if (sel_r >= RTCIA_IDX_ALM0 && sel_r <= RTCIA_IDX_ALMEND) begin
            ind_val = alm_r[alm_off[3:0]];
        end else if (sel_r == RTCIA_IDX_CTRL) begin
            ind_val = {3'b000, set_pend_r, cap_pend_r, auto_r, aen_r, run_r};
        end else if (sel_r == RTCIA_IDX_ROUTE) begin
            ind_val = {5'b00000, route_r};
        end else if (sel_r == RTCIA_IDX_FLAGS) begin
            ind_val = {5'b00000, flags_r};
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            run_r      <= 1'b0;
            aen_r      <= 1'b0;
            auto_r     <= 1'b0;
            cap_pend_r <= 1'b0;
            set_pend_r <= 1'b0;
            route_r    <= 3'b000;
        end else begin
            if (ind_wr && sel_r == RTCIA_IDX_CTRL) begin
                run_r  <= sfr_req.wdata[RTCIA_CTL_RUN];
                aen_r  <= sfr_req.wdata[RTCIA_CTL_AEN];
                auto_r <= sfr_req.wdata[RTCIA_CTL_AUTO];
            end
            if (ind_wr && sel_r == RTCIA_IDX_ROUTE) begin
                route_r <= sfr_req.wdata[2:0];
            end
            // Transfers are accepted only when the same control write sets the run bit
            if (ind_wr && sel_r == RTCIA_IDX_CTRL &&
                sfr_req.wdata[RTCIA_CTL_CAP] && sfr_req.wdata[RTCIA_CTL_RUN]) begin
                cap_pend_r <= 1'b1;
            end else if (tick) begin
                cap_pend_r <= 1'b0;
            end
            if (ind_wr && sel_r == RTCIA_IDX_CTRL &&
                sfr_req.wdata[RTCIA_CTL_SET] && sfr_req.wdata[RTCIA_CTL_RUN]) begin
                set_pend_r <= 1'b1;
            end else if (tick) begin
                set_pend_r <= 1'b0;
            end
        end
    end

    // Capture bytes: hardware capture wins over a software byte write
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            for (int b = 0; b < 4; b++) cap_r[b] <= RTCIA_ZERO8;
        end else if (tick && cap_pend_r) begin
            for (int b = 0; b < 4; b++) cap_r[b] <= timer_r[8*b +: 8];
        end else if (ind_wr && sel_r < RTCIA_IDX_CTRL) begin
            cap_r[sel_r[1:0]] <= sfr_req.wdata;
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            for (int b = 0; b < RTCIA_NUM_ALM*4; b++) alm_r[b] <= RTCIA_ZERO8;
        end else if (ind_wr && sel_r >= RTCIA_IDX_ALM0 && sel_r <= RTCIA_IDX_ALMEND) begin
            alm_r[alm_off[3:0]] <= sfr_req.wdata;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Timer and alarm comparators
    logic aen_clr;

    assign aen_clr = ind_wr && sel_r == RTCIA_IDX_CTRL && !sfr_req.wdata[RTCIA_CTL_AEN];

    for (genvar i = 0; i < RTCIA_NUM_ALM; i++) begin : g_alm
        logic sw_clr;
        assign alm_val[i] = {alm_r[4*i+3], alm_r[4*i+2], alm_r[4*i+1], alm_r[4*i]};
        assign ev[i]      = tick && run_r && aen_r && (timer_r == alm_val[i]);
        assign sw_clr     = aen_clr ||
                            (ind_wr && sel_r == RTCIA_IDX_FLAGS && sfr_req.wdata[i]);
        always_ff @(posedge clk or negedge resetn) begin
            if (!resetn) begin
                flags_r[i] <= 1'b0;
            end else begin
                flags_r[i] <= ev[i] || (flags_r[i] && !sw_clr);
            end
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            timer_r <= 32'h0000_0000;
        end else if (tick) begin
            if (set_pend_r) begin
                timer_r <= cap_val;
            end else if (auto_r && ev[0]) begin
                timer_r <= 32'h0000_0000;
            end else if (run_r) begin
                timer_r <= timer_r + 32'h0000_0001;
            end
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            alarm_req <= '0;
        end else begin
            alarm_req.reset_req <= |flags_r && route_r[RTCIA_RT_RESET];
            alarm_req.wake_req  <= |flags_r && route_r[RTCIA_RT_WAKE];
            alarm_req.irq_req   <= |flags_r && route_r[RTCIA_RT_IRQ];
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Checks
    logic [13:0] pend_cnt_r;

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            pend_cnt_r <= 14'h0000;
        end else if (cap_pend_r || set_pend_r) begin
            pend_cnt_r <= pend_cnt_r + 14'h0001;
        end else begin
            pend_cnt_r <= 14'h0000;
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (!resetn);

    property p_lock_read;
        sfr_req.rd && sfr_req.addr == RTCIA_LOCK_SFR |=> sfr_rdata == RTCIA_UNLOCKED;
    endproperty
    a_lock_read: assert property (p_lock_read) else $error("lock read not 0x02");

    property p_lock_write;
        lock_wr |=> $stable(sel_r) && $stable(auto_read_enable_r) && $stable(run_r) && $stable(aen_r);
    endproperty
    a_lock_write: assert property (p_lock_write) else $error("lock write changed state");

    property p_addr_read;
        sfr_req.rd && sfr_req.addr == RTCIA_ADDR_SFR |=> !sfr_rdata[7] && !sfr_rdata[5];
    endproperty
    a_addr_read: assert property (p_addr_read) else $error("reserved bits not zero");

    property p_step;
        ind_step && !addr_wr |=> sel_r == $past(sel_r) + 5'h01;
    endproperty
    a_step: assert property (p_step) else $error("select did not increment");

    property p_xfer;
        pend_cnt_r <= 14'(RTCIA_XFER_MAX_CYC);
    endproperty
    a_xfer: assert property (p_xfer) else $error("transfer too slow");

    property p_match;
        ev[0] |-> timer_r == alm_val[0] && aen_r;
    endproperty
    a_match: assert property (p_match) else $error("alarm without equality");

    property p_auto;
        ev[0] && auto_r && !set_pend_r |=> timer_r == 32'h0000_0000;
    endproperty
    a_auto: assert property (p_auto) else $error("auto reset missed");

    property p_alm1;
        ev[1] && !ev[0] && !set_pend_r |=> timer_r == $past(timer_r) + 32'h0000_0001;
    endproperty
    a_alm1: assert property (p_alm1) else $error("alarm 1 disturbed timer");

    property p_aen_clr;
        aen_clr |=> flags_r == $past(ev);
    endproperty
    a_aen_clr: assert property (p_aen_clr) else $error("flags not cleared");

    property p_flag_set;
        $rose(flags_r[0]) |-> $past(aen_r) && $past(tick);
    endproperty
    a_flag_set: assert property (p_flag_set) else $error("flag set while disabled");

endmodule

//--- sim/rtcia_top_test.sv
// Self-checking testbench of the clock indirect access and alarm block.
// Assumes the register port contract of the design: one-cycle strobes,
// read data one cycle after the read edge, slow tick every RTCIA_SLOW_DIV clk.
`timescale 1ns/100ps
module rtcia_top_test
    import rtcia_pkg::*;
;
    localparam int LIMIT = 90000;
    localparam logic [7:0] ALM0_VAL = 8'h03;

    logic             clk;
    logic             resetn;
    rtcia_sfr_req_t   req;
    logic [7:0]       rdata;
    rtcia_alarm_req_t alm;
    int               fails = 0;
    int               comparisons = 0;
    int               cyc = 0;
    int               t_one;
    int               t_two;
    logic [7:0]       got;

    rtcia_top i_dut (
        .clk       (clk),
        .resetn    (resetn),
        .sfr_req   (req),
        .sfr_rdata (rdata),
        .alarm_req (alm)
    );

    ////////////////////////////////////////////////////////////////////////
    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end

    // Cycle ceiling against hangs
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == LIMIT) begin
            fails = fails + 1;
            end_sim();
        end
    end

    ////////////////////////////////////////////////////////////////////////
    task automatic end_sim();
        $display("comparisons %0d fails %0d", comparisons, fails);
        if (fails == 0 && comparisons > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        comparisons = comparisons + 1;
        if (g !== e) begin
            fails = fails + 1;
            $display("mismatch at %0t: got %h expected %h", $time, g, e);
        end
    endtask

    // Write strobe for one cycle, then two idle cycles before the next access
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge clk);
        req.addr = a;
        req.wdata = d;
        req.wr = 1'b1;
        @(negedge clk);
        req.wr = 1'b0;
        @(negedge clk);
    endtask

    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(negedge clk);
        req.addr = a;
        req.rd = 1'b1;
        @(negedge clk);
        req.rd = 1'b0;
        @(negedge clk);
        d = rdata;
    endtask

    task automatic rdchk(input logic [7:0] a, input logic [7:0] e);
        rd(a, got);
        chk(32'(got), 32'(e));
    endtask

    task automatic iwr(input logic [4:0] idx, input logic [7:0] v);
        wr(RTCIA_ADDR_SFR, {3'h0, idx});
        wr(RTCIA_DATA_SFR, v);
    endtask

    task automatic wait_alarm(output int at);
        int n;
        n = 0;
        while (alm == 3'h0 && n < 6 * RTCIA_SLOW_DIV) begin
            @(negedge clk);
            n = n + 1;
        end
        at = cyc;
    endtask

    ////////////////////////////////////////////////////////////////////////
    initial begin
        resetn = 1'b0;
        req = '0;
        repeat (10) @(negedge clk);
        resetn = 1'b1;

        rdchk(RTCIA_LOCK_SFR, RTCIA_UNLOCKED);
        rdchk(RTCIA_ADDR_SFR, 8'h00);
        wr(RTCIA_LOCK_SFR, 8'hff);
        rdchk(RTCIA_LOCK_SFR, RTCIA_UNLOCKED);
        rdchk(RTCIA_ADDR_SFR, 8'h00);
        rdchk(8'h3c, 8'h00);
        wr(RTCIA_ADDR_SFR, 8'hff);
        rdchk(RTCIA_ADDR_SFR, 8'h5f);
        $display("test registers done");

        // Alarm programmed with events disabled, bytes, then enabled later
        iwr(RTCIA_IDX_CTRL, 8'h00);
        wr(RTCIA_ADDR_SFR, {3'h0, RTCIA_IDX_ALM0});
        wr(RTCIA_DATA_SFR, ALM0_VAL);
        for (int i = 1; i < 4; i++) begin
            wr(RTCIA_DATA_SFR, 8'h00);
        end
        rdchk(RTCIA_ADDR_SFR, 8'h0c);
        // Alarms 1 and 2 at 0x100: out of reach while auto reset cycles 0..3
        for (int i = 0; i < 8; i++) begin
            wr(RTCIA_DATA_SFR, (i % 4 == 1) ? 8'h01 : 8'h00);
        end
        iwr(RTCIA_IDX_CTRL, 8'h00);
        rdchk(RTCIA_ADDR_SFR, 8'h04);
        for (int m = 0; m < 2; m++) begin
            wr(RTCIA_ADDR_SFR, {1'b0, m[0], 1'b0, RTCIA_IDX_ALM0});
            rdchk(RTCIA_DATA_SFR, ALM0_VAL);
            for (int i = 1; i < 4; i++) begin
                rdchk(RTCIA_DATA_SFR, 8'h00);
            end
            rdchk(RTCIA_ADDR_SFR, {1'b0, m[0], 1'b0, 5'h0c});
        end
        $display("test indirect access done");

        iwr(RTCIA_IDX_ROUTE, 8'h07);
        iwr(RTCIA_IDX_CTRL, 8'h07);
        wait_alarm(t_one);
        chk(32'(alm), 32'h7);
        iwr(RTCIA_IDX_ROUTE, 8'h01);
        chk(32'(alm), 32'h4);
        iwr(RTCIA_IDX_ROUTE, 8'h02);
        chk(32'(alm), 32'h2);
        iwr(RTCIA_IDX_ROUTE, 8'h04);
        chk(32'(alm), 32'h1);
        iwr(RTCIA_IDX_ROUTE, 8'h07);
        chk(32'(alm), 32'h7);
        iwr(RTCIA_IDX_FLAGS, 8'h01);
        chk(32'(alm), 32'h0);
        wait_alarm(t_two);
        chk(32'(alm), 32'h7);
        chk(32'(t_two - t_one), 32'((ALM0_VAL + 1) * RTCIA_SLOW_DIV));
        $display("test alarm and auto reset done");

        iwr(RTCIA_IDX_CTRL, 8'h05);
        chk(32'(alm), 32'h0);
        repeat (5 * RTCIA_SLOW_DIV) @(negedge clk);
        chk(32'(alm), 32'h0);
        $display("test alarm disable done");

        // Set loads capture bytes 0xfe; alarms 1 and 2 hit 0x100 without reset
        wr(RTCIA_ADDR_SFR, {3'h0, RTCIA_IDX_CAP0});
        wr(RTCIA_DATA_SFR, 8'hfe);
        for (int i = 1; i < 4; i++) begin
            wr(RTCIA_DATA_SFR, 8'h00);
        end
        wr(RTCIA_DATA_SFR, 8'h10);
        rdchk(RTCIA_DATA_SFR, 8'h00);
        wr(RTCIA_DATA_SFR, 8'h17);
        wait_alarm(t_one);
        chk(32'(alm), 32'h7);
        wr(RTCIA_ADDR_SFR, {3'h0, RTCIA_IDX_FLAGS});
        rdchk(RTCIA_DATA_SFR, 8'h06);
        iwr(RTCIA_IDX_CTRL, 8'h0f);
        repeat (2 * RTCIA_SLOW_DIV) @(negedge clk);
        rdchk(RTCIA_DATA_SFR, 8'h07);
        wr(RTCIA_ADDR_SFR, {3'h0, RTCIA_IDX_CAP0});
        rdchk(RTCIA_DATA_SFR, 8'h01);
        rdchk(RTCIA_DATA_SFR, 8'h01);
        rdchk(RTCIA_DATA_SFR, 8'h00);
        rdchk(RTCIA_DATA_SFR, 8'h00);
        $display("test set and capture done");
        end_sim();
    end
endmodule
